/* src/asr_defs.svh */
`ifndef ASR_DEFS_SVH
`define ASR_DEFS_SVH

// ****************************************
// Register indices (byte address = index * 4)
// ****************************************
`define ASR_IDX_LANE7    8'h2e
`define ASR_IDX_LANE8    8'h2f
`define ASR_IDX_CTRL     8'h30
`define ASR_IDX_STAT     8'h31

// ****************************************
// Reset values
// ****************************************
`define ASR_RST_LANE7    8'h06
`define ASR_RST_LANE8    8'h07
`define ASR_RST_CTRL     8'h00

// ****************************************
// Field positions
// ****************************************
`define ASR_RSVD_BIT     7
`define ASR_SRC_MSB      6
`define ASR_SRC_LSB      5
`define ASR_SLOT_MSB     4
`define ASR_SLOT_LSB     0
`define ASR_FMT_MSB      1
`define ASR_FMT_LSB      0
`define ASR_WLEN_MSB     3
`define ASR_WLEN_LSB     2

// ****************************************
// Bus answers and frame limits
// ****************************************
`define ASR_RESP_OKAY    2'h0
`define ASR_RESP_SLVERR  2'h2
`define ASR_LAST_SLOT    5'h1f

`endif

/* src/asr_pkg.sv */
package asr_pkg;

  typedef enum logic [1:0] {
    ASR_SRC_OFF,
    ASR_SRC_PLAY,
    ASR_SRC_LOOP,
    ASR_SRC_PEER
  } asr_src_t;

  typedef enum logic [1:0] {
    ASR_FMT_TDM,
    ASR_FMT_I2S,
    ASR_FMT_LJ,
    ASR_FMT_RSVD
  } asr_fmt_t;

  typedef enum logic [1:0] {
    ASR_WLEN_16,
    ASR_WLEN_20,
    ASR_WLEN_24,
    ASR_WLEN_32
  } asr_wlen_t;

endpackage

/* src/asr_lane_capture.sv */
`timescale 1ns/100ps
module asr_lane_capture (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        bit_en_i,
  input  wire logic        bit_val_i,
  input  wire logic [4:0]  bit_idx_i,
  input  wire logic        last_i,
  output logic      [31:0] word_o,
  output logic             done_o
);

  logic [31:0] shift_reg;
  logic [31:0] shift_next;
  logic [31:0] word_reg;
  logic        done_reg;

  // ****************************************
  // MSB-first assembly, left justified
  // ****************************************
  always_comb begin
    shift_next = (bit_idx_i == 5'h00) ? 32'h0 : shift_reg;
    shift_next[5'h1f - bit_idx_i] = bit_val_i;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      shift_reg <= 32'h0;
    end else if (bit_en_i) begin
      shift_reg <= shift_next;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      word_reg <= 32'h0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= bit_en_i & last_i;
      if (bit_en_i & last_i) begin
        word_reg <= shift_next;
      end
    end
  end

  assign word_o = word_reg;
  assign done_o = done_reg;

endmodule // asr_lane_capture

/* src/asr_rx_route.sv */
// Notes on behaviour
// - Lane 7 source: 0 off, 1 playback 7, 2 record 3 loopback, 3 peer 2.
// - Lane 8 source: 0 off, 1 playback 8, 2 record 4 loopback, 3 peer 3.
// - TDM takes lane 7 word from slot equal to its 5-bit field; resets 0x06.
// - I2S or LJ: field values 0 to 15 pick left slots 0 to 15.
// - I2S or LJ: field values 16 to 31 pick right slots 0 to 15.
// - Lane 8 slot field maps like lane 7; its byte resets to 0x07.
// - Bit 7 of each lane byte reads zero; software writes only zero there.
`timescale 1ns/100ps
`include "asr_defs.svh"
module asr_rx_route (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic [11:0] s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic      [1:0]  s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [11:0] s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic      [31:0] s_axi_rdata_o,
  output logic      [1:0]  s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  input  wire logic        sclk_i,
  input  wire logic        fsync_i,
  input  wire logic        sdata_i,
  input  wire logic        peer_sdata_i,
  input  wire logic [31:0] rec_ch3_word_i,
  input  wire logic [31:0] rec_ch4_word_i,
  output logic      [31:0] lane7_word_o,
  output logic             lane7_valid_o,
  output logic      [31:0] lane8_word_o,
  output logic             lane8_valid_o
);

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [2:0] reg_decode(input logic [11:0] addr);
    logic [9:0] idx;
    idx = addr[11:2];
    if (idx == {2'h0, `ASR_IDX_LANE7}) return 3'h4;
    else if (idx == {2'h0, `ASR_IDX_LANE8}) return 3'h5;
    else if (idx == {2'h0, `ASR_IDX_CTRL}) return 3'h6;
    else if (idx == {2'h0, `ASR_IDX_STAT}) return 3'h7;
    else return 3'h0;
  endfunction

  function automatic logic slot_hit(input logic tdm, input logic [4:0] field,
                                    input logic right, input logic [4:0] slot);
    if (tdm) return slot == field;
    else return (slot == {1'b0, field[3:0]}) && (right == field[4]);
  endfunction

  function automatic logic src_bit(input asr_pkg::asr_src_t src, input logic play,
                                   input logic peer);
    return (src == asr_pkg::ASR_SRC_PEER) ? peer : play;
  endfunction

  function automatic logic src_serial(input asr_pkg::asr_src_t src);
    return (src == asr_pkg::ASR_SRC_PLAY) || (src == asr_pkg::ASR_SRC_PEER);
  endfunction

  // ****************************************
  // Declarations
  // ****************************************
  logic [7:0]  lane7_reg;
  logic [7:0]  lane8_reg;
  logic [7:0]  ctrl_reg;
  logic        awready_reg;
  logic        wready_reg;
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [11:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        arready_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic        wr_fire;
  logic [2:0]  wr_dec;
  logic [2:0]  rd_dec;
  logic [31:0] rd_word;
  logic [1:0]  sclk_sync_reg;
  logic [1:0]  fs_sync_reg;
  logic [1:0]  sd_sync_reg;
  logic [1:0]  pd_sync_reg;
  logic        sclk_d_reg;
  logic        fs_prev_reg;
  logic        bit_en;
  logic        fs_now;
  logic        tdm;
  logic        i2s;
  logic        half_start;
  logic        new_right;
  logic        frame_start;
  logic        cur_valid;
  logic [4:0]  cur_bit;
  logic [4:0]  cur_slot;
  logic        cur_right;
  logic        cur_last;
  logic [4:0]  wlen_last;
  logic [4:0]  bit_reg;
  logic [4:0]  slot_reg;
  logic        right_reg;
  logic        active_reg;
  logic        en7;
  logic        en8;
  logic [31:0] cap7_word;
  logic        cap7_done;
  logic [31:0] cap8_word;
  logic        cap8_done;
  logic [31:0] lane7_word_reg;
  logic        lane7_valid_reg;
  logic [31:0] lane8_word_reg;
  logic        lane8_valid_reg;
  asr_pkg::asr_src_t src7;
  asr_pkg::asr_src_t src8;
  asr_pkg::asr_fmt_t fmt;

  assign src7 = asr_pkg::asr_src_t'(lane7_reg[`ASR_SRC_MSB:`ASR_SRC_LSB]);
  assign src8 = asr_pkg::asr_src_t'(lane8_reg[`ASR_SRC_MSB:`ASR_SRC_LSB]);
  assign fmt  = asr_pkg::asr_fmt_t'(ctrl_reg[`ASR_FMT_MSB:`ASR_FMT_LSB]);

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  assign wr_fire = aw_held_reg & w_held_reg & ~bvalid_reg;
  assign wr_dec  = reg_decode(awaddr_reg);

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= 12'h0;
      wdata_reg   <= 32'h0;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `ASR_RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i & awready_reg) begin
        awaddr_reg  <= s_axi_awaddr_i;
        aw_held_reg <= 1'b1;
        awready_reg <= 1'b0;
      end
      if (s_axi_wvalid_i & wready_reg) begin
        wdata_reg  <= s_axi_wdata_i;
        wstrb_reg  <= s_axi_wstrb_i;
        w_held_reg <= 1'b1;
        wready_reg <= 1'b0;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_dec[2] ? `ASR_RESP_OKAY : `ASR_RESP_SLVERR;
      end
      if (bvalid_reg & s_axi_bready_i) begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      lane7_reg <= `ASR_RST_LANE7;
      lane8_reg <= `ASR_RST_LANE8;
      ctrl_reg  <= `ASR_RST_CTRL;
    end else if (wr_fire & wstrb_reg[0]) begin
      unique case (wr_dec)
        3'h4: lane7_reg <= {1'b0, wdata_reg[6:0]};
        3'h5: lane8_reg <= {1'b0, wdata_reg[6:0]};
        3'h6: ctrl_reg <= {4'h0, wdata_reg[3:0]};
        default: ;
      endcase
    end
  end

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  assign rd_dec = reg_decode(s_axi_araddr_i);

  always_comb begin
    unique case (rd_dec)
      3'h4: rd_word = {24'h0, lane7_reg};
      3'h5: rd_word = {24'h0, lane8_reg};
      3'h6: rd_word = {24'h0, ctrl_reg};
      3'h7: rd_word = {25'h0, active_reg, right_reg, slot_reg};
      default: rd_word = 32'h0;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0;
      rresp_reg   <= `ASR_RESP_OKAY;
    end else begin
      if (s_axi_arvalid_i & arready_reg) begin
        arready_reg <= 1'b0;
        rvalid_reg  <= 1'b1;
        rdata_reg   <= rd_word;
        rresp_reg   <= rd_dec[2] ? `ASR_RESP_OKAY : `ASR_RESP_SLVERR;
      end
      if (rvalid_reg & s_axi_rready_i) begin
        rvalid_reg  <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
  end

  // ****************************************
  // Serial pin synchronisers
  // ****************************************
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sclk_sync_reg <= 2'h0;
      fs_sync_reg   <= 2'h0;
      sd_sync_reg   <= 2'h0;
      pd_sync_reg   <= 2'h0;
      sclk_d_reg    <= 1'b0;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[0], sclk_i};
      fs_sync_reg   <= {fs_sync_reg[0], fsync_i};
      sd_sync_reg   <= {sd_sync_reg[0], sdata_i};
      pd_sync_reg   <= {pd_sync_reg[0], peer_sdata_i};
      sclk_d_reg    <= sclk_sync_reg[1];
    end
  end

  assign bit_en = sclk_sync_reg[1] & ~sclk_d_reg;
  assign fs_now = fs_sync_reg[1];

  // ****************************************
  // Frame and slot position
  // ****************************************
  assign tdm         = (fmt == asr_pkg::ASR_FMT_TDM) || (fmt == asr_pkg::ASR_FMT_RSVD);
  assign i2s         = (fmt == asr_pkg::ASR_FMT_I2S);
  assign half_start  = tdm ? (fs_now & ~fs_prev_reg) : (fs_now ^ fs_prev_reg);
  assign new_right   = i2s ? fs_now : ~fs_now;
  assign frame_start = half_start & (tdm | ~new_right);

  always_comb begin
    unique case (asr_pkg::asr_wlen_t'(ctrl_reg[`ASR_WLEN_MSB:`ASR_WLEN_LSB]))
      asr_pkg::ASR_WLEN_16: wlen_last = 5'h0f;
      asr_pkg::ASR_WLEN_20: wlen_last = 5'h13;
      asr_pkg::ASR_WLEN_24: wlen_last = 5'h17;
      asr_pkg::ASR_WLEN_32: wlen_last = 5'h1f;
    endcase
  end

  always_comb begin
    cur_valid = half_start ? ~i2s : active_reg;
    cur_bit   = half_start ? 5'h00 : bit_reg;
    cur_slot  = half_start ? 5'h00 : slot_reg;
    cur_right = tdm ? 1'b0 : (half_start ? new_right : right_reg);
    cur_last  = (cur_bit == wlen_last);
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      fs_prev_reg <= 1'b0;
      bit_reg     <= 5'h00;
      slot_reg    <= 5'h00;
      right_reg   <= 1'b0;
      active_reg  <= 1'b0;
    end else if (bit_en) begin
      fs_prev_reg <= fs_now;
      right_reg   <= cur_right;
      if (half_start & i2s) begin
        bit_reg    <= 5'h00;
        slot_reg   <= 5'h00;
        active_reg <= 1'b1;
      end else if (cur_valid) begin
        bit_reg    <= cur_last ? 5'h00 : cur_bit + 5'h01;
        slot_reg   <= cur_last ? cur_slot + 5'h01 : cur_slot;
        active_reg <= ~(cur_last && cur_slot == `ASR_LAST_SLOT);
      end
    end
  end

  // ****************************************
  // Lane capture
  // ****************************************
  assign en7 = bit_en & cur_valid & src_serial(src7)
             & slot_hit(tdm, lane7_reg[`ASR_SLOT_MSB:`ASR_SLOT_LSB], cur_right, cur_slot);
  assign en8 = bit_en & cur_valid & src_serial(src8)
             & slot_hit(tdm, lane8_reg[`ASR_SLOT_MSB:`ASR_SLOT_LSB], cur_right, cur_slot);

  asr_lane_capture u_cap7 (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .bit_en_i   (en7),
    .bit_val_i  (src_bit(src7, sd_sync_reg[1], pd_sync_reg[1])),
    .bit_idx_i  (cur_bit),
    .last_i     (cur_last),
    .word_o     (cap7_word),
    .done_o     (cap7_done)
  );

  asr_lane_capture u_cap8 (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .bit_en_i   (en8),
    .bit_val_i  (src_bit(src8, sd_sync_reg[1], pd_sync_reg[1])),
    .bit_idx_i  (cur_bit),
    .last_i     (cur_last),
    .word_o     (cap8_word),
    .done_o     (cap8_done)
  );

  // ****************************************
  // Lane outputs
  // ****************************************
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      lane7_word_reg  <= 32'h0;
      lane7_valid_reg <= 1'b0;
    end else begin
      lane7_valid_reg <= 1'b0;
      if (cap7_done & src_serial(src7)) begin
        lane7_word_reg  <= cap7_word;
        lane7_valid_reg <= 1'b1;
      end else if (bit_en & frame_start & src7 == asr_pkg::ASR_SRC_LOOP) begin
        lane7_word_reg  <= rec_ch3_word_i;
        lane7_valid_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      lane8_word_reg  <= 32'h0;
      lane8_valid_reg <= 1'b0;
    end else begin
      lane8_valid_reg <= 1'b0;
      if (cap8_done & src_serial(src8)) begin
        lane8_word_reg  <= cap8_word;
        lane8_valid_reg <= 1'b1;
      end else if (bit_en & frame_start & src8 == asr_pkg::ASR_SRC_LOOP) begin
        lane8_word_reg  <= rec_ch4_word_i;
        lane8_valid_reg <= 1'b1;
      end
    end
  end

  assign s_axi_awready_o = awready_reg;
  assign s_axi_wready_o  = wready_reg;
  assign s_axi_bresp_o   = bresp_reg;
  assign s_axi_bvalid_o  = bvalid_reg;
  assign s_axi_arready_o = arready_reg;
  assign s_axi_rdata_o   = rdata_reg;
  assign s_axi_rresp_o   = rresp_reg;
  assign s_axi_rvalid_o  = rvalid_reg;
  assign lane7_word_o    = lane7_word_reg;
  assign lane7_valid_o   = lane7_valid_reg;
  assign lane8_word_o    = lane8_word_reg;
  assign lane8_valid_o   = lane8_valid_reg;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  chk_lane7_loop_word: assert property (
    bit_en && frame_start && src7 == asr_pkg::ASR_SRC_LOOP && !cap7_done
    |=> lane7_valid_reg && lane7_word_reg == $past(rec_ch3_word_i))
    else $error("lane 7 loopback word not taken");
  chk_lane8_loop_word: assert property (
    bit_en && frame_start && src8 == asr_pkg::ASR_SRC_LOOP && !cap8_done
    |=> lane8_valid_reg && lane8_word_reg == $past(rec_ch4_word_i))
    else $error("lane 8 loopback word not taken");
  chk_lane7_reset_val: assert property (
    $past(rst_i) |-> lane7_reg == 8'h06)
    else $error("lane 7 byte reset value wrong");
  chk_tdm_slot_match: assert property (
    en7 && tdm |-> cur_slot == lane7_reg[4:0] && !cur_right)
    else $error("tdm capture from wrong slot");
  chk_left_half_pick: assert property (
    en7 && !tdm && !lane7_reg[4] |-> !cur_right && cur_slot == {1'b0, lane7_reg[3:0]})
    else $error("left half slot mismatch");
  chk_right_half_pick: assert property (
    en8 && !tdm && lane8_reg[4] |-> cur_right && cur_slot == {1'b0, lane8_reg[3:0]})
    else $error("right half slot mismatch");
  chk_lane8_reset_val: assert property (
    $past(rst_i) |-> lane8_reg == 8'h07 && lane8_reg[6:5] == 2'h0)
    else $error("lane 8 byte reset value wrong");
  chk_rsvd_reads_zero: assert property (
    s_axi_arvalid_i && arready_reg && rd_dec[2:1] == 2'h2 |=> rvalid_reg && !rdata_reg[7])
    else $error("reserved bit read as one");
  chk_off_lane_quiet: assert property (
    src7 == asr_pkg::ASR_SRC_OFF && $past(src7) == asr_pkg::ASR_SRC_OFF
    |-> !en7 && !lane7_valid_reg)
    else $error("disabled lane produced data");
  chk_one_per_slot: assert property (
    cap7_done |=> !cap7_done [*2])
    else $error("lane 7 captured twice in a row");

  cov_lane7_play: cover property (lane7_valid_reg && src7 == asr_pkg::ASR_SRC_PLAY);
  cov_lane8_peer: cover property (lane8_valid_reg && src8 == asr_pkg::ASR_SRC_PEER);
  cov_i2s_right: cover property (en7 && i2s && cur_right);
  cov_bad_addr: cover property (bvalid_reg && bresp_reg == `ASR_RESP_SLVERR);

endmodule // asr_rx_route

/* testbench/asr_serial_host.sv */
`timescale 1ns/100ps
// ****************************************
// Serial frame source on the far side
// ****************************************
module asr_serial_host (
  input  wire logic        core_clk_i,
  input  wire logic        go_i,
  input  wire logic [1:0]  fmt_i,
  input  wire logic [1:0]  wlen_i,
  input  wire logic [31:0] prim_i [32],
  input  wire logic [31:0] peer_i [32],
  output logic             sclk_o,
  output logic             fsync_o,
  output logic             sdata_o,
  output logic             peer_sdata_o,
  output logic             busy_o
);
  int   w;
  int   nh;
  logic is_i2s;
  logic hl;

  initial begin
    sclk_o = 1'b0;
    fsync_o = 1'b0;
    sdata_o = 1'b0;
    peer_sdata_o = 1'b0;
    busy_o = 1'b0;
  end

  // One bit cell, clock stands still outside frames
  task automatic send_bit(input logic fs, input logic d, input logic p);
    @(posedge core_clk_i);
    fsync_o      <= fs;
    sdata_o      <= d;
    peer_sdata_o <= p;
    repeat (4) @(posedge core_clk_i);
    sclk_o <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    sclk_o <= 1'b0;
  endtask

  always begin
    @(posedge core_clk_i);
    if (go_i === 1'b1) begin
      busy_o <= 1'b1;
      w      = (wlen_i == 2'h3) ? 32 : 16 + 4 * int'(wlen_i);
      is_i2s = (fmt_i == asr_pkg::ASR_FMT_I2S);
      nh     = (is_i2s || fmt_i == asr_pkg::ASR_FMT_LJ) ? 2 : 1;
      // Lead-in cell at the frame sync level opposite the first half
      send_bit(is_i2s, ~sdata_o, ~peer_sdata_o);
      for (int h = 0; h < nh; h++) begin
        hl = is_i2s ? h[0] : ~h[0];
        if (is_i2s) send_bit(hl, ~sdata_o, ~peer_sdata_o);
        for (int s = 0; s < 32 / nh; s++) begin
          for (int b = 0; b < w; b++) begin
            send_bit((nh == 1) ? (s == 0 && b == 0) : hl,
                     prim_i[h * 16 + s][31 - b], peer_i[h * 16 + s][31 - b]);
          end
        end
      end
      @(posedge core_clk_i);
      sdata_o      <= ~sdata_o;
      peer_sdata_o <= ~peer_sdata_o;
      busy_o       <= 1'b0;
    end
  end
endmodule // asr_serial_host

/* testbench/tb_asi_rx_slot_routing_ch7_ch8.sv */
`timescale 1ns/100ps
module tb_asi_rx_slot_routing_ch7_ch8;
  logic        clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, v7, v8;
  logic        sclk, fsync, sdata, psdata, busy, go;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rec3, rec4, w7, w8, g7, g8;
  logic [31:0] n_fail, checks, cyc, c7, c8, lfsr;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, fmt, wlen;
  logic [31:0] prim [32];
  logic [31:0] peer [32];
  logic [4:0]  slot_tab [4] = '{5'h00, 5'h1f, 5'h0f, 5'h10};

  asr_rx_route dut_u (
    .core_clk_i(clk), .rst_i(rst),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .sclk_i(sclk), .fsync_i(fsync),
    .sdata_i(sdata), .peer_sdata_i(psdata), .rec_ch3_word_i(rec3), .rec_ch4_word_i(rec4),
    .lane7_word_o(w7), .lane7_valid_o(v7), .lane8_word_o(w8), .lane8_valid_o(v8)
  );

  asr_serial_host host_u (
    .core_clk_i(clk), .go_i(go), .fmt_i(fmt), .wlen_i(wlen), .prim_i(prim), .peer_i(peer),
    .sclk_o(sclk), .fsync_o(fsync), .sdata_o(sdata), .peer_sdata_o(psdata), .busy_o(busy)
  );

  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  function automatic logic [31:0] exp_word(input logic [1:0] src, input logic [4:0] sl,
                                           input logic [31:0] rec);
    logic [31:0] m;
    m = ~(32'hffffffff >> ((wlen == 2'h3) ? 32 : 16 + 4 * int'(wlen)));
    case (src)
      2'h1: return prim[sl] & m;
      2'h2: return rec;
      2'h3: return peer[sl] & m;
      default: return 32'h0;
    endcase
  endfunction

  task automatic stop_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks = checks + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wchk(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
    logic got;
    got = 1'b0;
    @(posedge clk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= s;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!got) begin
      @(posedge clk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bready && bvalid === 1'b1) begin
        chk({30'h0, bresp}, {30'h0, er}, "bresp");
        bready <= 1'b0;
        got = 1'b1;
      end
    end
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic got;
    got = 1'b0;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!got) begin
      @(posedge clk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rready && rvalid === 1'b1) begin
        chk(rdata, ed, "rdata");
        chk({30'h0, rresp}, {30'h0, er}, "rresp");
        rready <= 1'b0;
        got = 1'b1;
      end
    end
  endtask

  // ****************************************
  // Capture monitor and timeout
  // ****************************************
  always @(posedge clk) begin
    cyc <= cyc + 32'h1;
    if (v7 === 1'b1) begin
      c7 <= c7 + 32'h1;
      g7 <= w7;
    end
    if (v8 === 1'b1) begin
      c8 <= c8 + 32'h1;
      g8 <= w8;
    end
    if (cyc == 32'd60000) begin
      n_fail = n_fail + 1;
      stop_test();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [1:0]  s7, s8, f;
    logic [4:0]  l7, l8;
    logic [31:0] b7, b8;
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, go} = 6'h0;
    {awaddr, araddr, wdata, wstrb, fmt, wlen} = 64'h0;
    {rec3, rec4, n_fail, checks, cyc, c7, c8} = 224'h0;
    lfsr = 32'h5da1;
    for (int k = 0; k < 32; k++) begin
      prim[k] = 32'h0;
      peer[k] = 32'h0;
    end
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rchk(12'hb8, 32'h06, 2'h0);
    rchk(12'hbc, 32'h07, 2'h0);
    rchk(12'hc4, 32'h00, 2'h0);
    wchk(12'hb8, 32'hffffff7f, 4'h1, 2'h0);
    rchk(12'hb8, 32'h7f, 2'h0);
    wchk(12'hbc, 32'hffffff7f, 4'h0, 2'h0);
    rchk(12'hbc, 32'h07, 2'h0);
    wchk(12'h100, 32'h55, 4'hf, 2'h2);
    rchk(12'h100, 32'h00, 2'h2);
    for (int i = 0; i < 6; i++) begin
      s7 = 2'((i + 1) % 4);
      s8 = 2'(i % 4);
      lfsr = nxt(lfsr);
      l7 = (i < 4) ? slot_tab[i] : lfsr[4:0];
      l8 = lfsr[12:8];
      f  = 2'((i == 3) ? 3 : i % 3);
      wchk(12'hc0, {28'h0, 2'(i % 4), f}, 4'h1, 2'h0);
      rchk(12'hc0, {28'h0, 2'(i % 4), f}, 2'h0);
      wchk(12'hb8, {25'h0, s7, l7}, 4'h1, 2'h0);
      wchk(12'hbc, {25'h0, s8, l8}, 4'h1, 2'h0);
      rchk(12'hbc, {25'h0, s8, l8}, 2'h0);
      fmt  <= f;
      wlen <= 2'(i % 4);
      for (int k = 0; k < 32; k++) begin
        lfsr = nxt(lfsr);
        prim[k] <= lfsr;
        lfsr = nxt(lfsr);
        peer[k] <= lfsr;
      end
      lfsr = nxt(lfsr);
      rec3 <= lfsr;
      rec4 <= ~lfsr;
      b7 = c7;
      b8 = c8;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      while (busy === 1'b1) @(posedge clk);
      repeat (20) @(posedge clk);
      chk(c7 - b7, (s7 == 2'h0) ? 32'h0 : 32'h1, "lane7 count");
      chk(c8 - b8, (s8 == 2'h0) ? 32'h0 : 32'h1, "lane8 count");
      if (s7 != 2'h0) chk(g7, exp_word(s7, l7, rec3), "lane7");
      if (s8 != 2'h0) chk(g8, exp_word(s8, l8, rec4), "lane8");
    end
    stop_test();
  end
endmodule // tb_asi_rx_slot_routing_ch7_ch8
